// ==== verilog/hcrt_pkg.sv ====
// Operation
// - Index selects register reached by data port
// - Total register holds characters per line minus five
// - Display end holds displayed characters minus one
// - Retrace asserts one clock after counter hits retrace start
// - Ports decode colour or mono by select bit
// - Blank end six bits, bit5 from retrace end
package hcrt_pkg;
  localparam logic [15:0] HCRT_IDX_MONO = 16'h03B4;
  localparam logic [15:0] HCRT_IDX_COLOR = 16'h03D4;
  localparam logic [4:0] HCRT_SEL_TOTAL = 5'h00;
  localparam logic [4:0] HCRT_SEL_DEND = 5'h01;
  localparam logic [4:0] HCRT_SEL_BSTART = 5'h02;
  localparam logic [4:0] HCRT_SEL_BEND = 5'h03;
  localparam logic [4:0] HCRT_SEL_RSTART = 5'h04;
  localparam logic [4:0] HCRT_SEL_REND = 5'h05;
  localparam logic [7:0] HCRT_RST_VAL = 8'h00;
  localparam logic [7:0] HCRT_TOTAL_ADJ = 8'h05;
  localparam int HCRT_SKEW_LSB = 5;
  localparam int HCRT_BEND5_BIT = 7;
  localparam int HCRT_IDX_BITS = 5;
endpackage

// ==== verilog/hcrt_if.sv ====
`timescale 1ns/1ps
interface hcrt_if;
  logic [7:0] total;
  logic [7:0] dend;
  logic [7:0] bstart;
  logic [5:0] bend;
  logic [1:0] skew;
  logic [7:0] rstart;
  modport regs (output total, dend, bstart, bend, skew, rstart);
  modport gen (input total, dend, bstart, bend, skew, rstart);
endinterface

// ==== verilog/hcrt_hgen.sv ====
`timescale 1ns/1ps
module hcrt_hgen
  import hcrt_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst_b,
  // Timing values
  hcrt_if.gen cfg,
  // Outputs
  output logic [7:0] hcount,
  output logic disp_en,
  output logic hblank,
  output logic hretrace
);
  logic [7:0] line_last;
  logic [2:0] de_pipe_ff;
  logic de_raw;
  logic [7:0] nxt_count;
  logic [7:0] count_ff;
  logic blank_ff;

  // Line is total plus five characters
  assign line_last = 8'(cfg.total + HCRT_TOTAL_ADJ - 8'h01);
  assign nxt_count = (count_ff >= line_last) ? 8'h00 : 8'(count_ff + 8'h01);

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      count_ff <= 8'h00;
    else
      count_ff <= nxt_count;

  assign de_raw = (count_ff <= cfg.dend);

  // Skew delays enable by whole character clocks
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      de_pipe_ff <= 3'h0;
    else
      de_pipe_ff <= {de_pipe_ff[1:0], de_raw};

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      disp_en <= 1'b0;
    else
      disp_en <= (cfg.skew == 2'h0) ? de_raw : de_pipe_ff[cfg.skew - 2'h1];

  // Blank end compares six low bits of count
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      blank_ff <= 1'b0;
    else if (count_ff == cfg.bstart)
      blank_ff <= 1'b1;
    else if (count_ff[5:0] == cfg.bend)
      blank_ff <= 1'b0;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      hretrace <= 1'b0;
    else
      hretrace <= (count_ff == cfg.rstart);

  assign hblank = blank_ff;
  assign hcount = count_ff;

  retrace_hit_a: assert property (@(posedge clk) disable iff (!rst_b)
    count_ff == cfg.rstart |=> hretrace)
    else $error("retrace not raised at start count");
  blank_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    count_ff == cfg.bstart |=> hblank)
    else $error("blank not raised at start count");
  line_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    count_ff >= line_last |=> count_ff == 8'h00)
    else $error("counter did not wrap");
  skew_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.skew == 2'h0 && $stable(cfg.skew) |=> disp_en == $past(de_raw))
    else $error("unskewed enable wrong");
  disp_width_a: assert property (@(posedge clk) disable iff (!rst_b)
    count_ff > cfg.dend && cfg.skew == 2'h0 |=> !disp_en)
    else $error("enable past display end");
  blank_end_a: assert property (@(posedge clk) disable iff (!rst_b)
    count_ff[5:0] == cfg.bend && count_ff != cfg.bstart |=> !hblank)
    else $error("blank not cleared at end count");
  wrap_c: cover property (@(posedge clk) disable iff (!rst_b)
    count_ff == 8'h00 ##1 count_ff == 8'h01);
  retr_c: cover property (@(posedge clk) disable iff (!rst_b) hretrace);
  skew_c: cover property (@(posedge clk) disable iff (!rst_b)
    cfg.skew == 2'h3 && disp_en);
endmodule // hcrt_hgen

// ==== verilog/hcrt_top.sv ====
`timescale 1ns/1ps
module hcrt_top
  import hcrt_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst_b,
  // Host I/O port
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_hit,
  // Emulation select and retrace end bit 7 source
  input wire logic color_emul,
  input wire logic bend_bit5,
  // Display timing
  output logic [7:0] hcount,
  output logic disp_en,
  output logic hblank,
  output logic hretrace
);
  hcrt_if cfg_if ();
  logic rst_s1_ff, rst_s2_ff;
  logic [7:0] index_ff;
  logic [7:0] total_ff, dend_ff, bstart_ff, bend_ff, rstart_ff;
  logic [15:0] base;
  logic idx_hit, dat_hit;
  logic [7:0] sel_val;

  // Reset released synchronously to avoid split release
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end

  assign base = color_emul ? HCRT_IDX_COLOR : HCRT_IDX_MONO;
  assign idx_hit = (io_addr == base);
  assign dat_hit = (io_addr == 16'(base + 16'h0001));
  assign io_hit = (io_wr | io_rd) & (idx_hit | dat_hit);

  always_ff @(posedge clk or negedge rst_s2_ff)
    if (!rst_s2_ff)
      index_ff <= HCRT_RST_VAL;
    else if (io_wr && idx_hit)
      index_ff <= {3'h0, io_wdata[HCRT_IDX_BITS-1:0]};

  // Data port write reaches indexed register
  always_ff @(posedge clk or negedge rst_s2_ff)
    if (!rst_s2_ff)
    begin
      total_ff <= HCRT_RST_VAL;
      dend_ff <= HCRT_RST_VAL;
      bstart_ff <= HCRT_RST_VAL;
      bend_ff <= HCRT_RST_VAL;
      rstart_ff <= HCRT_RST_VAL;
    end
    else if (io_wr && dat_hit)
      unique case (index_ff[4:0])
        HCRT_SEL_TOTAL: total_ff <= io_wdata;
        HCRT_SEL_DEND: dend_ff <= io_wdata;
        HCRT_SEL_BSTART: bstart_ff <= io_wdata;
        HCRT_SEL_BEND: bend_ff <= io_wdata;
        HCRT_SEL_RSTART: rstart_ff <= io_wdata;
        default: ;
      endcase

  always_comb
  begin
    unique case (index_ff[4:0])
      HCRT_SEL_TOTAL: sel_val = total_ff;
      HCRT_SEL_DEND: sel_val = dend_ff;
      HCRT_SEL_BSTART: sel_val = bstart_ff;
      HCRT_SEL_BEND: sel_val = bend_ff;
      HCRT_SEL_RSTART: sel_val = rstart_ff;
      default: sel_val = 8'h00;
    endcase
  end

  // Read data registered, valid cycle after strobe
  always_ff @(posedge clk or negedge rst_s2_ff)
    if (!rst_s2_ff)
      io_rdata <= 8'h00;
    else if (io_rd && idx_hit)
      io_rdata <= index_ff;
    else if (io_rd && dat_hit)
      io_rdata <= sel_val;

  assign cfg_if.total = total_ff;
  assign cfg_if.dend = dend_ff;
  assign cfg_if.bstart = bstart_ff;
  assign cfg_if.bend = {bend_bit5, bend_ff[4:0]};
  assign cfg_if.skew = bend_ff[HCRT_SKEW_LSB+1:HCRT_SKEW_LSB];
  assign cfg_if.rstart = rstart_ff;

  hcrt_hgen u_hgen (
    .clk(clk),
    .rst_b(rst_s2_ff),
    .cfg(cfg_if.gen),
    .hcount(hcount),
    .disp_en(disp_en),
    .hblank(hblank),
    .hretrace(hretrace)
  );

  index_store_a: assert property (@(posedge clk) disable iff (!rst_s2_ff)
    io_wr && idx_hit |=> index_ff == {3'h0, $past(io_wdata[4:0])})
    else $error("index not stored");
  port_decode_a: assert property (@(posedge clk) disable iff (!rst_s2_ff)
    color_emul && io_addr == 16'h03B5 |-> !dat_hit)
    else $error("mono data port hit in colour mode");
  mono_decode_a: assert property (@(posedge clk) disable iff (!rst_s2_ff)
    !color_emul && io_addr == 16'h03D5 |-> !dat_hit)
    else $error("colour data port hit in mono mode");
  // Unmatched writes must not disturb the selector
  refused_wr_a: assert property (@(posedge clk) disable iff (!rst_s2_ff)
    io_wr && !idx_hit && !dat_hit |=> index_ff == $past(index_ff))
    else $error("index changed by unmatched write");
  rdata_zero_a: assert property (@(posedge clk) disable iff (!rst_s2_ff)
    io_rd && dat_hit && index_ff[4:0] > HCRT_SEL_RSTART
      |=> io_rdata == 8'h00)
    else $error("unused index read not zero");
  total_write_a: assert property (@(posedge clk) disable iff (!rst_s2_ff)
    io_wr && dat_hit && index_ff[4:0] == HCRT_SEL_TOTAL
      |=> total_ff == $past(io_wdata))
    else $error("total register not written");
  wr_c: cover property (@(posedge clk) disable iff (!rst_s2_ff)
    io_wr && idx_hit ##1 io_wr && dat_hit);
endmodule // hcrt_top

// ==== sim/hcrt_host.sv ====
`timescale 1ns/1ps
module hcrt_host
(
  // System
  input wire logic clk,
  // Host port
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  initial
  begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // Released lines flip so stale values never match
  task automatic acc(input logic [15:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wr <= w;
    io_rd <= !w;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask
endmodule // hcrt_host

// ==== sim/crtc_horizontal_timing_regs_tb.sv ====
`timescale 1ns/1ps
module crtc_horizontal_timing_regs_tb;
  import hcrt_pkg::*;
  logic clk, rst_b, io_wr, io_rd, io_hit, color_emul, bend_bit5;
  logic disp_en, hblank, hretrace;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, hcount;
  int err_count = 0;
  int n_tests = 0;
  int ln, en, dl, bl, hc, bn;
  logic [7:0] rows [5] = '{8'h0B, 8'h07, 8'h09, 8'h0E, 8'h0C};
  hcrt_host u_hcrt_host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));
  hcrt_top u_hcrt_top (.clk(clk), .rst_b(rst_b), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_hit(io_hit), .color_emul(color_emul),
    .bend_bit5(bend_bit5), .hcount(hcount), .disp_en(disp_en),
    .hblank(hblank), .hretrace(hretrace));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_hcrt_host.acc(a, 1'b1, d);
  endtask
  // Samples the hit flag while the strobe stands
  task automatic xfer(input logic [15:0] a, input logic w,
                      input logic [7:0] d, input logic eh);
    logic h;
    fork
      u_hcrt_host.acc(a, w, d);
      begin
        @(posedge clk);
        #1;
        h = io_hit;
      end
    join
    chk({7'h00, h}, {7'h00, eh});
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00, 1'b1);
    #1;
    chk(io_rdata, exp);
  endtask
  // One line from retrace to retrace, offsets counted from retrace
  task automatic meas();
    int prev;
    int pb;
    @(posedge hretrace);
    #1;
    hc = hcount;
    ln = 0;
    en = 0;
    bn = 0;
    dl = -1;
    bl = -1;
    prev = disp_en;
    pb = hblank;
    do
    begin
      @(posedge clk);
      #1;
      ln++;
      en += disp_en;
      bn += hblank;
      if (disp_en && !prev && dl < 0) dl = ln;
      if (hblank && !pb && bl < 0) bl = ln;
      prev = disp_en;
      pb = hblank;
    end while (hretrace !== 1'b1);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #400000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    rst_b = 1'b0;
    color_emul = 1'b1;
    bend_bit5 = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(16'h03D5, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 5; i++)
    begin
      wr(16'h03D4, 8'(i));
      wr(16'h03D5, rows[i]);
      rd(16'h03D5, rows[i]);
    end
    $display("row test done");
    wr(16'h03D4, 8'hFF);
    rd(16'h03D4, 8'h1F);
    wr(16'h03D5, 8'h55);
    rd(16'h03D5, 8'h00);
    @(posedge clk);
    color_emul <= 1'b0;
    wr(16'h03B4, 8'h05);
    wr(16'h03B4, 8'h02);
    wr(16'h03B5, 8'h33);
    xfer(16'h03D5, 1'b1, 8'h44, 1'b0);
    rd(16'h03B5, 8'h33);
    @(posedge clk);
    color_emul <= 1'b1;
    wr(16'h03D4, 8'h02);
    rd(16'h03D5, 8'h33);
    wr(16'h03D5, 8'h09);
    $display("decode test done");
    meas();
    meas();
    chk(8'(ln), 8'h10);
    chk(8'(en), 8'h08);
    chk(8'(hc), 8'h0D);
    chk(8'(bl), 8'h0D);
    chk(8'(dl), 8'h04);
    chk(8'(bn), 8'h05);
    wr(16'h03D4, 8'h03);
    wr(16'h03D5, 8'h6E);
    meas();
    meas();
    chk(8'(dl), 8'h07);
    chk(8'(en), 8'h08);
    wr(16'h03D4, 8'h03);
    wr(16'h03D5, 8'h2E);
    meas();
    meas();
    chk(8'(dl), 8'h05);
    // Longer line so bit 5 of the end count can matter
    wr(16'h03D4, 8'h00);
    wr(16'h03D5, 8'h2B);
    @(posedge clk);
    bend_bit5 <= 1'b1;
    meas();
    meas();
    chk(8'(ln), 8'h30);
    chk(8'(bn), 8'h25);
    $display("timing test done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(hcount, 8'h00);
    chk({5'h00, disp_en, hblank, hretrace}, 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(16'h03D4, 8'h00);
    rd(16'h03D5, 8'h00);
    $display("reset rerun done");
    report_and_stop();
  end
endmodule // crtc_horizontal_timing_regs_tb
